// file: include/dbt_pkg.sv
package dbt_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_EVA_ADDR = 8'h04;
    localparam logic [7:0] REG_EVA_CFG = 8'h08;
    localparam logic [7:0] REG_EVB_ADDR = 8'h0c;
    localparam logic [7:0] REG_EVB_CFG = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_TRACE_IDX = 8'h18;
    localparam logic [7:0] REG_TRACE_W0 = 8'h1c;
    localparam logic [7:0] REG_TRACE_W1 = 8'h20;
    localparam logic [7:0] REG_CMD = 8'h24;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_BRK_LSB = 0;
    localparam int CTRL_FULL_BRK = 3;
    localparam int CTRL_TTYPE = 4;
    localparam int CTRL_START_LSB = 5;
    localparam int CTRL_STOP_LSB = 8;
    localparam int CTRL_PICKUP = 11;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // event config fields
    localparam int EVC_ENABLE = 0;
    localparam int EVC_WRITE_ONLY = 1;
    localparam int EVC_READ_ONLY = 2;
    localparam int EVC_MASK_EN = 3;
    localparam int EVC_MASK_LSB = 4;
    localparam int EVC_MASK_W = 4;

    // command register fields
    localparam int CMD_CLR_TRACE = 0;

    // status register fields
    localparam int STS_TRACING = 0;
    localparam int STS_FLAG_A = 1;
    localparam int STS_FLAG_B = 2;
    localparam int STS_FULL = 3;
    localparam int STS_BREAK = 4;
    localparam int STS_COUNT_LSB = 8;

    // ------------------------------------------------------------
    // selector encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        EV_NONE = 3'h0,
        EV_A = 3'h1,
        EV_A_OR_B = 3'h2,
        EV_A_AND_B = 3'h3,
        EV_B_THEN_A = 3'h4
    } dbt_event_sel_t;

    // start selector reuses the event codes, code 0 meaning program start
    localparam logic [2:0] START_GO = 3'h0;
    // stop selector: 0 = program halt, 5 = buffer full, others event codes
    localparam logic [2:0] STOP_BREAK = 3'h0;
    localparam logic [2:0] STOP_FULL = 3'h5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dbt_pkg

// file: rtl/dbt_event_trace.sv
`timescale 1ns/1ps
// What this block does
// R1: after reset the break selector is none; matches alone never halt.
// R2: selector A halts on an A match; A-or-B halts on either match.
// R3: A-and-B selector halts only once both channels have matched.
// R4: B-then-A selector halts on an A match after an earlier B match.
// R5: optional break on trace buffer full, combinable with any event break.
// R6: trace-full break is off after configuration reset until enabled.
// R7: branch mode (default) records source and destination of each taken branch.
// R8: data-access mode records event match accesses instead of branches.
// R9: default start setting begins capture when the user program starts.
// R10: start may also be A match, A-or-B match, or both matched.
// R11: sequential start begins capture on an A match following a B match.
// R12: default stop setting ends capture when the user program halts.
// R13: buffer-full stop ends capture once trace storage is full.
// R14: stop may also be A match, A-or-B match, or both matched.
// R15: sequential stop ends capture on an A match following a B match.
// R16: data-access filter records A matches only (default) or A-or-B matches.
// R17: an event start does not record its trigger; the next match is recorded.
// R18: start and stop true together: stop is ignored, capture proceeds.
// R19: target reset during a run clears match flags and trace records.
// R20: only processor bus accesses are traced, never transfer engine accesses.
// R21: channels A and B each hold exactly one data-access match condition.
// R22: address match may ignore 1 to 15 low address bits.
// R23: sticky per-channel match flags, cleared at program start, feed combined conditions.
// R24: one capture flag, set by start, cleared by stop; records only while set.
module dbt_event_trace #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16,
    parameter int DEPTH = 64
) (
    input wire logic MCLK, // system clock, 50 MHz
    input wire logic RESETN, // synchronous reset, active low
    input wire logic [7:0] S_AXI_AWADDR, // write address
    input wire logic S_AXI_AWVALID, // write address valid
    output logic S_AXI_AWREADY, // write address ready
    input wire logic [31:0] S_AXI_WDATA, // write data
    input wire logic [3:0] S_AXI_WSTRB, // write byte strobes
    input wire logic S_AXI_WVALID, // write data valid
    output logic S_AXI_WREADY, // write data ready
    output logic [1:0] S_AXI_BRESP, // write response
    output logic S_AXI_BVALID, // write response valid
    input wire logic S_AXI_BREADY, // write response ready
    input wire logic [7:0] S_AXI_ARADDR, // read address
    input wire logic S_AXI_ARVALID, // read address valid
    output logic S_AXI_ARREADY, // read address ready
    output logic [31:0] S_AXI_RDATA, // read data
    output logic [1:0] S_AXI_RRESP, // read response
    output logic S_AXI_RVALID, // read data valid
    input wire logic S_AXI_RREADY, // read data ready
    input wire logic CPU_RUN, // user program executing
    input wire logic TARGET_RESET, // pin or watchdog reset of the target
    input wire logic ACC_VALID, // data access on the bus this cycle
    input wire logic ACC_ENGINE, // access made by transfer_controller_engine
    input wire logic ACC_WRITE, // access is a write
    input wire logic [ADDR_W-1:0] ACC_ADDR, // access address
    input wire logic [DATA_W-1:0] ACC_DATA, // access data
    input wire logic BR_VALID, // taken branch this cycle
    input wire logic [ADDR_W-1:0] BR_SRC, // branch source address
    input wire logic [ADDR_W-1:0] BR_DST, // branch destination address
    output logic BREAK_REQ, // halt request to the core
    output logic TRACE_ACTIVE // capture flag
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int IW = $clog2(DEPTH);

    if (ADDR_W < 16 || ADDR_W > 32 || DATA_W > 28 || DEPTH < 2 || DEPTH > 256) begin : g_chk
        $error("dbt_event_trace: unsupported parameter values");
    end

    // ------------
    // configuration registers
    // ------------
    logic [31:0] ctrl;
    logic [31:0] ev_addr [2];
    logic [31:0] ev_cfg [2];
    logic [IW-1:0] trace_idx;

    dbt_pkg::dbt_event_sel_t brk_sel;
    logic [2:0] start_sel;
    logic [2:0] stop_sel;
    assign brk_sel = dbt_pkg::dbt_event_sel_t'(ctrl[dbt_pkg::CTRL_BRK_LSB +: 3]);
    assign start_sel = ctrl[dbt_pkg::CTRL_START_LSB +: 3];
    assign stop_sel = ctrl[dbt_pkg::CTRL_STOP_LSB +: 3];

    // ------------
    // run edges
    // ------------
    logic run_q;
    logic run_start;
    logic run_stop;
    logic tgt_clear;
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            run_q <= 1'b0;
        end else begin
            run_q <= CPU_RUN;
        end
    end
    assign run_start = CPU_RUN && !run_q;
    assign run_stop = !CPU_RUN && run_q;
    assign tgt_clear = TARGET_RESET && CPU_RUN; // R19

    // ------------
    // event channels
    // ------------
    logic [1:0] hit;
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [ADDR_W-1:0] care;
        logic [3:0] mbits;
        logic rw_ok;
        assign mbits = ev_cfg[c][dbt_pkg::EVC_MASK_LSB +: dbt_pkg::EVC_MASK_W];
        // mask count 0 behaves as unmasked; 1..15 low bits ignored
        assign care = ev_cfg[c][dbt_pkg::EVC_MASK_EN] ? ({ADDR_W{1'b1}} << mbits) : {ADDR_W{1'b1}}; // R22
        assign rw_ok = !(ev_cfg[c][dbt_pkg::EVC_WRITE_ONLY] && !ACC_WRITE)
                       && !(ev_cfg[c][dbt_pkg::EVC_READ_ONLY] && ACC_WRITE);
        // one address and one config word per channel, so one live condition
        assign hit[c] = ev_cfg[c][dbt_pkg::EVC_ENABLE] && ACC_VALID && !ACC_ENGINE && CPU_RUN && rw_ok
                        && (((ACC_ADDR ^ ev_addr[c][ADDR_W-1:0]) & care) == '0); // R21 R20
    end

    // sticky flags; a match in the clear cycle still sets
    logic flag_a;
    logic flag_b;
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            flag_a <= 1'b0;
            flag_b <= 1'b0;
        end else begin
            flag_a <= hit[0] || (flag_a && !run_start && !tgt_clear); // R23 R19
            flag_b <= hit[1] || (flag_b && !run_start && !tgt_clear); // R23 R19
        end
    end

    function automatic logic ev_cond(input logic [2:0] sel, input logic ha, input logic hb,
                                     input logic fa, input logic fb);
        case (sel)
            3'h1: ev_cond = ha;
            3'h2: ev_cond = ha || hb;
            3'h3: ev_cond = (ha || fa) && (hb || fb) && (ha || hb); // R3
            3'h4: ev_cond = ha && fb; // R4
            default: ev_cond = 1'b0;
        endcase
    endfunction

    // ------------
    // trace storage
    // ------------
    logic [31:0] mem_w0 [DEPTH];
    logic [31:0] mem_w1 [DEPTH];
    logic [CW-1:0] count;
    logic full;
    logic tracing;
    logic clr_cmd;
    logic pick;
    logic rec_en;
    assign full = (count == CW'(DEPTH));
    assign pick = ctrl[dbt_pkg::CTRL_PICKUP] ? (hit[0] || hit[1]) : hit[0]; // R16
    // tracing is the registered flag, so an event that starts capture is not itself recorded
    assign rec_en = tracing && CPU_RUN && !full
                    && (ctrl[dbt_pkg::CTRL_TTYPE] ? pick : BR_VALID); // R17 R24 R7 R8

    always_ff @(posedge MCLK) begin
        if (rec_en) begin
            if (ctrl[dbt_pkg::CTRL_TTYPE]) begin
                mem_w0[count[IW-1:0]] <= 32'(ACC_ADDR); // R8
                mem_w1[count[IW-1:0]] <= {hit, ACC_WRITE, (29-DATA_W)'(0), ACC_DATA};
            end else begin
                mem_w0[count[IW-1:0]] <= 32'(BR_SRC); // R7
                mem_w1[count[IW-1:0]] <= 32'(BR_DST);
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN || tgt_clear || clr_cmd) begin
            count <= '0; // R19
        end else if (rec_en) begin
            count <= count + CW'(1);
        end
    end

    // ------------
    // capture flag
    // ------------
    logic start_hit;
    logic stop_hit;
    always_comb begin
        start_hit = (start_sel == dbt_pkg::START_GO) ? run_start
                    : ev_cond(start_sel, hit[0], hit[1], flag_a, flag_b); // R9 R10 R11
        case (stop_sel)
            dbt_pkg::STOP_BREAK: stop_hit = run_stop; // R12
            dbt_pkg::STOP_FULL: stop_hit = full; // R13
            default: stop_hit = ev_cond(stop_sel, hit[0], hit[1], flag_a, flag_b); // R14 R15
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN || tgt_clear) begin
            tracing <= 1'b0;
        end else if (start_hit && CPU_RUN) begin
            tracing <= 1'b1; // R18
        end else if (stop_hit || !CPU_RUN) begin
            tracing <= 1'b0; // R24
        end
    end

    // ------------
    // break request
    // ------------
    logic brk_hit;
    assign brk_hit = ev_cond(brk_sel, hit[0], hit[1], flag_a, flag_b) // R1 R2 R3 R4
                     || (ctrl[dbt_pkg::CTRL_FULL_BRK] && full && CPU_RUN); // R5
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            BREAK_REQ <= 1'b0;
        end else if (brk_hit) begin
            BREAK_REQ <= 1'b1;
        end else if (!CPU_RUN) begin
            BREAK_REQ <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            TRACE_ACTIVE <= 1'b0;
        end else begin
            TRACE_ACTIVE <= (tracing || (start_hit && CPU_RUN)) && !tgt_clear
                            && !((stop_hit || !CPU_RUN) && !(start_hit && CPU_RUN));
        end
    end

    // ------------
    // bus slave: write path
    // ------------
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_ok;
    assign wr_fire = aw_have && w_have && !S_AXI_BVALID;

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            aw_have <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            aw_addr <= 8'h00;
        end else if (S_AXI_AWREADY && S_AXI_AWVALID) begin
            aw_have <= 1'b1;
            S_AXI_AWREADY <= 1'b0;
            aw_addr <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_have <= 1'b0;
        end else if (!aw_have && !S_AXI_BVALID) begin
            S_AXI_AWREADY <= 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            w_have <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (S_AXI_WREADY && S_AXI_WVALID) begin
            w_have <= 1'b1;
            S_AXI_WREADY <= 1'b0;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            w_have <= 1'b0;
        end else if (!w_have && !S_AXI_BVALID) begin
            S_AXI_WREADY <= 1'b1;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            old[8*i +: 8] = st[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
        merge = old;
    endfunction

    always_comb begin
        case (aw_addr)
            dbt_pkg::REG_CTRL, dbt_pkg::REG_EVA_ADDR, dbt_pkg::REG_EVA_CFG, dbt_pkg::REG_EVB_ADDR,
            dbt_pkg::REG_EVB_CFG, dbt_pkg::REG_TRACE_IDX, dbt_pkg::REG_CMD, dbt_pkg::REG_STATUS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            ctrl <= dbt_pkg::CTRL_RESET; // R1 R6
            ev_addr[0] <= 32'h0000_0000;
            ev_addr[1] <= 32'h0000_0000;
            ev_cfg[0] <= 32'h0000_0000;
            ev_cfg[1] <= 32'h0000_0000;
            trace_idx <= '0;
        end else if (wr_fire) begin
            case (aw_addr)
                dbt_pkg::REG_CTRL: ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_0fff;
                dbt_pkg::REG_EVA_ADDR: ev_addr[0] <= merge(ev_addr[0], w_data, w_strb);
                dbt_pkg::REG_EVA_CFG: ev_cfg[0] <= merge(ev_cfg[0], w_data, w_strb) & 32'h0000_00ff;
                dbt_pkg::REG_EVB_ADDR: ev_addr[1] <= merge(ev_addr[1], w_data, w_strb);
                dbt_pkg::REG_EVB_CFG: ev_cfg[1] <= merge(ev_cfg[1], w_data, w_strb) & 32'h0000_00ff;
                dbt_pkg::REG_TRACE_IDX: trace_idx <= w_data[IW-1:0];
                default: trace_idx <= trace_idx;
            endcase
        end
    end

    assign clr_cmd = wr_fire && (aw_addr == dbt_pkg::REG_CMD) && w_strb[0] && w_data[dbt_pkg::CMD_CLR_TRACE];

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= dbt_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? dbt_pkg::RESP_OKAY : dbt_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // ------------
    // bus slave: read path
    // ------------
    logic [31:0] status;
    logic [31:0] rd_val;
    logic rd_ok;
    assign status = {16'h0000, (8)'(count), 3'h0, BREAK_REQ, full, flag_b, flag_a, tracing};

    always_comb begin
        rd_ok = 1'b1;
        case (S_AXI_ARADDR)
            dbt_pkg::REG_CTRL: rd_val = ctrl;
            dbt_pkg::REG_EVA_ADDR: rd_val = ev_addr[0];
            dbt_pkg::REG_EVA_CFG: rd_val = ev_cfg[0];
            dbt_pkg::REG_EVB_ADDR: rd_val = ev_addr[1];
            dbt_pkg::REG_EVB_CFG: rd_val = ev_cfg[1];
            dbt_pkg::REG_STATUS: rd_val = status;
            dbt_pkg::REG_TRACE_IDX: rd_val = 32'(trace_idx);
            dbt_pkg::REG_TRACE_W0: rd_val = mem_w0[trace_idx];
            dbt_pkg::REG_TRACE_W1: rd_val = mem_w1[trace_idx];
            dbt_pkg::REG_CMD: rd_val = 32'h0000_0000;
            default: begin
                rd_val = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= dbt_pkg::RESP_OKAY;
        end else if (S_AXI_ARREADY && S_AXI_ARVALID) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_val;
            S_AXI_RRESP <= rd_ok ? dbt_pkg::RESP_OKAY : dbt_pkg::RESP_SLVERR;
        end else if (S_AXI_RVALID) begin
            S_AXI_RVALID <= !S_AXI_RREADY;
        end else begin
            S_AXI_ARREADY <= 1'b1;
        end
    end
endmodule : dbt_event_trace

// file: test/dbt_sva.sv
`timescale 1ns/1ps
module dbt_sva (
    input wire logic MCLK, // clock
    input wire logic RESETN, // reset, active low
    input wire logic S_AXI_AWVALID, // write address valid
    input wire logic S_AXI_AWREADY, // write address ready
    input wire logic S_AXI_WVALID, // write data valid
    input wire logic S_AXI_WREADY, // write data ready
    input wire logic S_AXI_BVALID, // write response valid
    input wire logic S_AXI_ARVALID, // read address valid
    input wire logic S_AXI_ARREADY, // read address ready
    input wire logic S_AXI_RVALID, // read data valid
    input wire logic CPU_RUN, // program running
    input wire logic BREAK_REQ, // halt request
    input wire logic TRACE_ACTIVE // capture flag
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    AST_RST_OUT: assert property (disable iff (1'b0) !RESETN |=> !BREAK_REQ && !TRACE_ACTIVE)
        else $error("outputs after reset");
    AST_BRK_HOLD: assert property (BREAK_REQ && CPU_RUN |=> BREAK_REQ)
        else $error("break dropped");
    AST_BRK_DROP: assert property (!CPU_RUN ##1 !CPU_RUN |-> !BREAK_REQ)
        else $error("break held");
    AST_BRK_RUN: assert property ($rose(BREAK_REQ) |-> $past(CPU_RUN))
        else $error("break without run");
    AST_TRC_OFF: assert property (!CPU_RUN |=> !TRACE_ACTIVE)
        else $error("capture after halt");
    AST_B_LAT: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    AST_R_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read data late");
    AST_WR_BUSY: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while busy");
    AST_RD_BUSY: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while busy");
endmodule : dbt_sva

// file: test/dbt_cpu_model.sv
`timescale 1ns/1ps
module dbt_cpu_model #(parameter int ADDR_W = 20, parameter int DATA_W = 16) (
    input wire logic MCLK, // clock
    output logic CPU_RUN, // program running
    output logic TARGET_RESET, // target reset
    output logic ACC_VALID, // access strobe
    output logic ACC_ENGINE, // engine access
    output logic ACC_WRITE, // write access
    output logic [ADDR_W-1:0] ACC_ADDR, // access address
    output logic [DATA_W-1:0] ACC_DATA, // access data
    output logic BR_VALID, // branch strobe
    output logic [ADDR_W-1:0] BR_SRC, // branch source
    output logic [ADDR_W-1:0] BR_DST // branch target
);
    initial {CPU_RUN, TARGET_RESET, ACC_VALID, ACC_ENGINE, ACC_WRITE, ACC_ADDR, ACC_DATA, BR_VALID, BR_SRC, BR_DST} = '0;
    task run(input logic v);
        @(posedge MCLK);
        CPU_RUN <= v;
    endtask : run
    // idle buses show the inverse so stale values never pass as a match
    task acc(input logic [ADDR_W-1:0] a, input logic w, e, input logic [DATA_W-1:0] d);
        @(posedge MCLK);
        {ACC_VALID, ACC_WRITE, ACC_ENGINE, ACC_ADDR, ACC_DATA} <= {1'b1, w, e, a, d};
        @(posedge MCLK);
        {ACC_VALID, ACC_ENGINE, ACC_ADDR, ACC_DATA} <= {2'b0, ~a, ~d};
    endtask : acc
    task br(input logic [ADDR_W-1:0] s, t);
        @(posedge MCLK);
        {BR_VALID, BR_SRC, BR_DST} <= {1'b1, s, t};
        @(posedge MCLK);
        {BR_VALID, BR_SRC, BR_DST} <= {1'b0, ~s, ~t};
    endtask : br
    task treset;
        @(posedge MCLK);
        TARGET_RESET <= 1'b1;
        @(posedge MCLK);
        TARGET_RESET <= 1'b0;
    endtask : treset
endmodule : dbt_cpu_model

// file: test/dbt_tb.sv
`timescale 1ns/1ps
module tb;
    logic MCLK, RESETN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, BREAK_REQ, TRACE_ACTIVE;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic CPU_RUN, TARGET_RESET, ACC_VALID, ACC_ENGINE, ACC_WRITE, BR_VALID;
    logic [19:0] ACC_ADDR, BR_SRC, BR_DST;
    logic [15:0] ACC_DATA;
    int bad_count = 0, n_checks = 0, cyc = 0;
    dbt_pkg::dbt_event_sel_t sels [5] = '{dbt_pkg::EV_NONE, dbt_pkg::EV_A, dbt_pkg::EV_A_OR_B,
        dbt_pkg::EV_A_AND_B, dbt_pkg::EV_B_THEN_A};
    logic [2:0] accs [5] = '{3'h2, 3'h5, 3'h1, 3'h2, 3'h2}; // bit j set: step j hits channel B
    logic [2:0] exps [5] = '{3'h0, 3'h6, 3'h7, 3'h6, 3'h4};

    dbt_event_trace #(.DEPTH(4)) u_dut (.MCLK, .RESETN, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
        .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
        .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
        .S_AXI_RREADY, .CPU_RUN, .TARGET_RESET, .ACC_VALID, .ACC_ENGINE, .ACC_WRITE, .ACC_ADDR, .ACC_DATA,
        .BR_VALID, .BR_SRC, .BR_DST, .BREAK_REQ, .TRACE_ACTIVE);
    dbt_cpu_model u_cpu (.MCLK, .CPU_RUN, .TARGET_RESET, .ACC_VALID, .ACC_ENGINE, .ACC_WRITE, .ACC_ADDR,
        .ACC_DATA, .BR_VALID, .BR_SRC, .BR_DST);

    initial begin
        MCLK = 0;
        forever #10 MCLK = ~MCLK;
    end
    // ------------
    // bus master and helpers
    // ------------
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] s, e, input string n);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : tick
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = dbt_pkg::RESP_OKAY,
            input logic [3:0] sb = 4'hf);
        logic aw, w;
        {aw, w} = 2'b00;
        @(posedge MCLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= v;
        S_AXI_WSTRB <= sb;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        while (!(aw && w)) begin
            @(posedge MCLK);
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw = 1;
                S_AXI_AWVALID <= 0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w = 1;
                S_AXI_WVALID <= 0;
            end
        end
        do @(posedge MCLK); while (S_AXI_BVALID !== 1'b1);
        S_AXI_BREADY <= 0;
        chk(S_AXI_BRESP, er, "bresp");
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er = dbt_pkg::RESP_OKAY);
        @(posedge MCLK);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        do @(posedge MCLK); while (S_AXI_ARREADY !== 1'b1);
        S_AXI_ARVALID <= 0;
        do @(posedge MCLK); while (S_AXI_RVALID !== 1'b1);
        S_AXI_RREADY <= 0;
        v = S_AXI_RDATA;
        chk(S_AXI_RRESP, er, "rresp");
    endtask : rd
    task rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] t;
        rd(a, t);
        chk(t, e, n);
    endtask : rdchk
    function automatic logic [31:0] mk(input logic [2:0] b, input logic f, y, input logic [2:0] st, sp);
        mk = {21'h0, sp, st, y, f, b};
    endfunction : mk

    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            bad_count++;
            test_done;
        end
    end
    // ------------
    // scenarios
    // ------------
    initial begin
        {RESETN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
        repeat (10) @(posedge MCLK);
        RESETN <= 1'b1;
        tick(2);
        rdchk(dbt_pkg::REG_CTRL, dbt_pkg::CTRL_RESET, "ctrl");
        rd(8'hfc, d, dbt_pkg::RESP_SLVERR);
        chk(d, 32'h0, "unmapped");
        wr(8'hfc, 32'h1, dbt_pkg::RESP_SLVERR);
        wr(dbt_pkg::REG_EVA_ADDR, 32'h100);
        wr(dbt_pkg::REG_EVA_CFG, 32'h1);
        wr(dbt_pkg::REG_EVB_ADDR, 32'h5a5a_0200, dbt_pkg::RESP_OKAY, 4'h3);
        wr(dbt_pkg::REG_EVB_CFG, 32'h1);
        u_cpu.run(1);
        tick(2);
        chk(TRACE_ACTIVE, 1'b1, "go start");
        u_cpu.br(20'h12345, 20'h0abcd);
        u_cpu.run(0);
        tick(2);
        chk(TRACE_ACTIVE, 1'b0, "halt stop");
        wr(dbt_pkg::REG_TRACE_IDX, 32'h0);
        rdchk(dbt_pkg::REG_TRACE_W0, 32'h12345, "br src");
        rdchk(dbt_pkg::REG_TRACE_W1, 32'h0abcd, "br dst");
        rdchk(dbt_pkg::REG_STATUS, 32'h100, "count");
        for (int i = 0; i < 5; i++) begin
            wr(dbt_pkg::REG_CTRL, mk(sels[i], 0, 0, dbt_pkg::START_GO, dbt_pkg::STOP_BREAK));
            u_cpu.run(1);
            for (int j = 0; j < 3; j++) begin
                u_cpu.acc(accs[i][j] ? 20'h200 : 20'h100, 0, 0, 16'h0);
                tick(2);
                chk(BREAK_REQ, exps[i][j], "break");
            end
            u_cpu.run(0);
            tick(2);
        end
        // start and stop on the same A hit: start must win
        wr(dbt_pkg::REG_CTRL, mk(dbt_pkg::EV_NONE, 0, 1, dbt_pkg::EV_A, dbt_pkg::EV_A));
        u_cpu.run(1);
        u_cpu.acc(20'h100, 0, 0, 16'h0);
        tick(2);
        chk(TRACE_ACTIVE, 1'b1, "same cycle");
        u_cpu.run(0);
        wr(dbt_pkg::REG_CMD, 32'h1);
        wr(dbt_pkg::REG_CTRL, mk(dbt_pkg::EV_NONE, 0, 1, dbt_pkg::EV_A, dbt_pkg::EV_B_THEN_A));
        u_cpu.run(1);
        tick(2);
        chk(TRACE_ACTIVE, 1'b0, "event start idle");
        u_cpu.acc(20'h100, 0, 0, 16'h0011);
        tick(2);
        chk(TRACE_ACTIVE, 1'b1, "event start");
        u_cpu.acc(20'h100, 1, 1, 16'h5555);
        u_cpu.acc(20'h100, 1, 0, 16'h1234);
        u_cpu.acc(20'h200, 0, 0, 16'h0022);
        rdchk(dbt_pkg::REG_STATUS, 32'h107, "data count");
        wr(dbt_pkg::REG_CTRL, mk(dbt_pkg::EV_NONE, 0, 1, dbt_pkg::START_GO, dbt_pkg::EV_B_THEN_A));
        u_cpu.acc(20'h100, 0, 0, 16'h0033);
        tick(2);
        chk(TRACE_ACTIVE, 1'b0, "seq stop");
        wr(dbt_pkg::REG_TRACE_IDX, 32'h0);
        rdchk(dbt_pkg::REG_TRACE_W0, 32'h100, "da addr");
        rdchk(dbt_pkg::REG_TRACE_W1, 32'h6000_1234, "da info");
        u_cpu.run(0);
        wr(dbt_pkg::REG_CMD, 32'h1);
        wr(dbt_pkg::REG_CTRL, mk(dbt_pkg::EV_NONE, 1, 0, dbt_pkg::START_GO, dbt_pkg::STOP_FULL));
        u_cpu.run(1);
        for (int i = 0; i < 4; i++) u_cpu.br(20'(i), 20'(i + 8));
        tick(2);
        chk(TRACE_ACTIVE, 1'b0, "full stop");
        chk(BREAK_REQ, 1'b1, "full break");
        wr(dbt_pkg::REG_EVA_CFG, 32'h4b);
        u_cpu.acc(20'h10f, 0, 0, 16'h0);
        rdchk(dbt_pkg::REG_STATUS, 32'h418, "full status");
        u_cpu.acc(20'h10f, 1, 0, 16'h0);
        rdchk(dbt_pkg::REG_STATUS, 32'h41a, "masked hit");
        u_cpu.treset;
        tick(2);
        rd(dbt_pkg::REG_STATUS, d);
        chk({d[15:8], d[2:1]}, 10'h0, "target reset");
        u_cpu.run(0);
        tick(2);
        test_done;
    end
endmodule : tb

bind dbt_event_trace dbt_sva u_sva (.MCLK, .RESETN, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .CPU_RUN, .BREAK_REQ,
    .TRACE_ACTIVE);
